// >>> fdc_host.sv
`timescale 1ns/10ps
module fdc_host
  import fdc_pkg::*;
(
  input wire logic aclk,
  output fdc_pins_s pins
);
  // ----------------------------------------
  // Host controller model
  // ----------------------------------------
  // Released lines show the inverse value, so stale data never passes.
  initial begin
    pins = '1;
    pins.dsp = 1'b0;
    pins.sclk = 1'b0;
  end
  // Field order is select, output enable, reset, protect, deep sleep.
  task automatic ctl(input logic [6:0] c);
    {pins.sel_n, pins.oe_n, pins.frst_n, pins.wp_n, pins.dsp} <= c;
    @(posedge aclk);
  endtask
  task automatic latch(input logic [7:0] a);
    pins.adv_n <= 1'b0;
    pins.addr <= a;
    @(posedge aclk);
    pins.adv_n <= 1'b1;
    @(posedge aclk);
    pins.addr <= ~a;
    @(posedge aclk);
  endtask
  // The sync clock only moves inside a read, so it cannot count down stale work.
  task automatic slatch(input logic [7:0] a);
    pins.adv_n <= 1'b0;
    pins.addr <= a;
    pins.sclk <= 1'b1;
    @(posedge aclk);
    pins.sclk <= 1'b0;
    pins.adv_n <= 1'b1;
    @(posedge aclk);
    pins.addr <= ~a;
    @(posedge aclk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      pins.sclk <= 1'b1;
      @(posedge aclk);
      pins.sclk <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    pins.data <= d;
    pins.we_n <= 1'b0;
    @(posedge aclk);
    pins.we_n <= 1'b1;
    @(posedge aclk);
    pins.data <= ~d;
    @(posedge aclk);
  endtask
endmodule

// >>> fdc_pkg.sv
package fdc_pkg;
  localparam int NUM_DIES = 2;
  localparam int NUM_BLKS = 4;
  localparam int DIE_W = 1;
  localparam int BLK_W = 2;
  localparam int IDX_W = DIE_W + BLK_W;
  localparam int ADDR_W = 8;
  localparam int AXI_AW = 8;
  localparam int READ_LAT = 3;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [AXI_AW-1:0] ECR_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] DIETYPE_OFS = 8'h04;
  localparam logic [AXI_AW-1:0] STATUS_OFS = 8'h08;
  localparam logic [AXI_AW-1:0] LOCK_OFS = 8'h0c;
  localparam logic [3:0] ECR_RST = 4'h0;
  localparam logic [NUM_DIES-1:0] DIETYPE_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Pin command opcodes, carried in data bits 15:12 of a write
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_PROG = 4'h4;
  localparam logic [3:0] OP_LOCK = 4'h1;
  localparam logic [3:0] OP_LOCKDN = 4'h2;
  localparam logic [3:0] OP_UNLOCK = 4'hd;

  typedef struct packed {
    logic sync;
    logic wait_hi;
    logic ds_hi;
    logic ds_en;
  } fdc_ecr_s;

  typedef struct packed {
    logic [NUM_DIES-1:0] sel_n;
    logic oe_n;
    logic we_n;
    logic frst_n;
    logic [1:0] wp_n;
    logic dsp;
    logic sclk;
    logic adv_n;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
  } fdc_pins_s;
endpackage

// >>> fdc_top.sv
`timescale 1ns/10ps
module fdc_top
  import fdc_pkg::*;
#(
  parameter int READ_LATENCY = READ_LAT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fdc_pins_s pins,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic data_invalid_flag,
  output logic data_invalid_oe
);
  localparam logic [3:0] LAT_INIT = 4'(READ_LATENCY);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  fdc_pins_s pin_q;
  fdc_ecr_s ecr_r;
  logic [NUM_DIES-1:0] nand_mask_r;
  logic [11:0] mem_r [NUM_DIES*NUM_BLKS];
  logic [NUM_DIES*NUM_BLKS-1:0] locked_r;
  logic [NUM_DIES*NUM_BLKS-1:0] lockdn_r;
  logic [ADDR_W-1:0] addr_r;
  logic [3:0] lat_r;
  logic adv_seen_r;
  logic ds_r;
  logic [7:0] wr_cnt_r;
  logic [7:0] rej_cnt_r;
  logic [15:0] data_r;
  logic flag_r;
  logic [DIE_W-1:0] wr_die;
  logic [DIE_W-1:0] rd_die;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic [3:0] opcode;
  logic sel_any;
  logic wr_evt;
  logic sync_edge;
  logic adv_rise;
  logic lat_take;
  logic wp_die;
  logic unlock_ok;
  logic aw_full_r;
  logic w_full_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [NUM_DIES*NUM_BLKS*2-1:0] lock_word;

  // ---------------------------------------------------------------
  // Pin sampling and edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= '1;
    end else begin
      pin_q <= pins;
    end
  end

  // Lowest selected die wins; hosts should never select two at once.
  always_comb begin
    wr_die = '0;
    rd_die = '0;
    for (int d = NUM_DIES - 1; d >= 0; d--) begin
      if (!pin_q.sel_n[d]) begin
        wr_die = DIE_W'(d);
      end
      if (!pins.sel_n[d]) begin
        rd_die = DIE_W'(d);
      end
    end
  end

  assign sel_any = ~&pins.sel_n;
  assign wr_idx = {wr_die, addr_r[BLK_W-1:0]};
  assign rd_idx = {rd_die, addr_r[BLK_W-1:0]};
  assign opcode = pin_q.data[15:12];
  assign sync_edge = !pin_q.sclk && pins.sclk;
  assign adv_rise = !pin_q.adv_n && pins.adv_n;
  // The write completes at the strobe's rising edge, using what was held while it was low.
  assign wr_evt = !pin_q.we_n && pins.we_n && !(&pin_q.sel_n) && pins.frst_n && !ds_r;
  assign lat_take = ecr_r.sync ? (sync_edge && !pins.adv_n && !adv_seen_r) : adv_rise;

  // Stack mode is implied by any die marked as NAND in the die type register.
  assign wp_die = (nand_mask_r != '0) ?
                  (nand_mask_r[wr_die] ? pin_q.wp_n[1] : pin_q.wp_n[0]) :
                  ((wr_die == '0) ? pin_q.wp_n[0] : pin_q.wp_n[1]);
  assign unlock_ok = !lockdn_r[wr_idx] || wp_die;

  // ---------------------------------------------------------------
  // Block locks and array
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.frst_n) begin
      locked_r <= '1;
      lockdn_r <= '0;
    end else if (wr_evt) begin
      unique case (opcode)
        OP_LOCK: begin
          locked_r[wr_idx] <= 1'b1;
        end
        OP_LOCKDN: begin
          locked_r[wr_idx] <= 1'b1;
          lockdn_r[wr_idx] <= 1'b1;
        end
        OP_UNLOCK: begin
          if (unlock_ok) begin
            locked_r[wr_idx] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_DIES * NUM_BLKS; i++) begin
        mem_r[i] <= '0;
      end
    end else if (wr_evt && opcode == OP_PROG && !locked_r[wr_idx]) begin
      mem_r[wr_idx] <= pin_q.data[11:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_cnt_r <= '0;
      rej_cnt_r <= '0;
    end else if (wr_evt) begin
      wr_cnt_r <= wr_cnt_r + 8'h01;
      if ((opcode == OP_UNLOCK && !unlock_ok) || (opcode == OP_PROG && locked_r[wr_idx])) begin
        rej_cnt_r <= rej_cnt_r + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Address latch and read latency
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.frst_n) begin
      addr_r <= '0;
      lat_r <= '0;
      adv_seen_r <= 1'b0;
    end else begin
      if (pins.adv_n) begin
        adv_seen_r <= 1'b0;
      end else if (lat_take) begin
        adv_seen_r <= 1'b1;
      end
      if (lat_take && !ds_r) begin
        addr_r <= ecr_r.sync ? pins.addr : pin_q.addr;
        lat_r <= LAT_INIT;
      end else if (lat_r != '0 && (!ecr_r.sync || sync_edge)) begin
        lat_r <= lat_r - 4'h1;
      end
    end
  end

  // Deep sleep follows the pin level only while enabled; a level change needs one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.frst_n) begin
      ds_r <= 1'b0;
    end else begin
      ds_r <= ecr_r.ds_en && (pins.dsp == ecr_r.ds_hi);
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_r <= '0;
      flag_r <= 1'b0;
    end else begin
      data_r <= {lockdn_r[rd_idx], locked_r[rd_idx], 2'b00, mem_r[rd_idx]};
      flag_r <= ((lat_r != '0) || ds_r || !pins.frst_n) == ecr_r.wait_hi;
    end
  end

  assign data_out = data_r;
  assign data_invalid_flag = flag_r;
  assign data_oe = sel_any && !pins.oe_n;
  assign data_invalid_oe = sel_any && !pins.oe_n;

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign do_wr = aw_full_r && w_full_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_r <= 1'b0;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= (awaddr_r == ECR_OFS || awaddr_r == DIETYPE_OFS ||
                    awaddr_r == STATUS_OFS || awaddr_r == LOCK_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Settings fall back to defaults on either reset, so a flash reset also disarms deep sleep.
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins.frst_n) begin
      ecr_r <= ECR_RST;
      nand_mask_r <= DIETYPE_RST;
    end else if (do_wr && wstrb_r[0]) begin
      if (awaddr_r == ECR_OFS) begin
        ecr_r <= wdata_r[3:0];
      end
      if (awaddr_r == DIETYPE_OFS) begin
        nand_mask_r <= wdata_r[NUM_DIES-1:0];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_DIES * NUM_BLKS; i++) begin
      lock_word[2*i+:2] = {lockdn_r[i], locked_r[i]};
    end
  end

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ECR_OFS: rd_word[3:0] = ecr_r;
      DIETYPE_OFS: rd_word[NUM_DIES-1:0] = nand_mask_r;
      STATUS_OFS: rd_word[23:0] = {rej_cnt_r, wr_cnt_r, 5'h00, lat_r == '0, !pins.frst_n, ds_r};
      LOCK_OFS: rd_word[NUM_DIES*NUM_BLKS*2-1:0] = lock_word;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_oe_on;
    (!pins.oe_n && sel_any) |-> (data_oe && data_invalid_oe);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("data drivers off while enabled");

  property p_oe_off;
    (pins.oe_n || &pins.sel_n) |-> (!data_oe && !data_invalid_oe);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drivers on while disabled");

  property p_rst_nowr;
    !pins.frst_n |=> (wr_cnt_r == $past(wr_cnt_r) && lat_r == 4'h0 && locked_r == '1);
  endproperty
  a_rst_nowr: assert property (p_rst_nowr) else $error("activity under flash reset");

  property p_resume;
    (pins.frst_n && !pin_q.we_n && pins.we_n && !(&pin_q.sel_n) && !ds_r)
      |=> wr_cnt_r == $past(wr_cnt_r) + 8'h01;
  endproperty
  a_resume: assert property (p_resume) else $error("write lost after reset release");

  property p_wait_lvl;
    (lat_r != 4'h0) |=> data_invalid_flag == $past(ecr_r.wait_hi);
  endproperty
  a_wait_lvl: assert property (p_wait_lvl) else $error("invalid flag at wrong level");

  property p_wait_on;
    (!pins.oe_n && !pins.sel_n[0]) |-> data_invalid_oe;
  endproperty
  a_wait_on: assert property (p_wait_on) else $error("invalid flag not driven");

  property p_we_only;
    ($past(aresetn) && $changed(wr_cnt_r)) |-> ($past(pin_q.we_n) == 1'b0 && $past(pins.we_n));
  endproperty
  a_we_only: assert property (p_we_only) else $error("write without strobe");

  property p_lockdn_hold;
    (wr_evt && opcode == OP_UNLOCK && lockdn_r[wr_idx] && !wp_die) |=> locked_r[$past(wr_idx)];
  endproperty
  a_lockdn_hold: assert property (p_lockdn_hold) else $error("lock-down unlocked");

  property p_unlock_ok;
    (wr_evt && opcode == OP_UNLOCK && wp_die) |=> !locked_r[$past(wr_idx)];
  endproperty
  a_unlock_ok: assert property (p_unlock_ok) else $error("unlock refused");

  property p_wp_plain;
    (nand_mask_r == '0) |-> wp_die == ((wr_die == '0) ? pin_q.wp_n[0] : pin_q.wp_n[1]);
  endproperty
  a_wp_plain: assert property (p_wp_plain) else $error("wrong protect input");

  property p_wp_stack;
    (nand_mask_r != '0 && !nand_mask_r[wr_die]) |-> wp_die == pin_q.wp_n[0];
  endproperty
  a_wp_stack: assert property (p_wp_stack) else $error("NOR die not on protect one");

  property p_ds_gate;
    !ecr_r.ds_en |=> !ds_r;
  endproperty
  a_ds_gate: assert property (p_ds_gate) else $error("deep sleep while disabled");

  property p_sync_cnt;
    (ecr_r.sync && pins.frst_n && lat_r != 4'h0 && !sync_edge && !lat_take) |=> $stable(lat_r);
  endproperty
  a_sync_cnt: assert property (p_sync_cnt) else $error("latency moved off sync edge");

  property p_async_latch;
    (!ecr_r.sync && adv_rise && !ds_r && pins.frst_n)
      |=> (addr_r == $past(pin_q.addr) && lat_r == LAT_INIT);
  endproperty
  a_async_latch: assert property (p_async_latch) else $error("address not latched");

  property p_bresp;
    do_wr |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response");

  c_prog: cover property (wr_evt && opcode == OP_PROG && !locked_r[wr_idx]);
  c_refused: cover property (wr_evt && opcode == OP_UNLOCK && !unlock_ok);
  c_ds_entry: cover property ($rose(ds_r));
  c_sync_read: cover property (ecr_r.sync && lat_take ##[1:40] lat_r == 4'h0);
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top
  import fdc_pkg::*;
;
  typedef struct packed {
    logic [6:0] c;
    logic e;
  } fdc_row_s;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  fdc_pins_s pins;
  logic [15:0] data_out;
  logic data_oe, data_invalid_oe, data_invalid_flag;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  fdc_row_s rows[5] = '{'{7'h6e, 1'h0}, '{7'h4e, 1'h1}, '{7'h5e, 1'h0},
                        '{7'h2e, 1'h1}, '{7'h1e, 1'h0}};
  fdc_top fdc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .data_out,
    .data_oe, .data_invalid_flag, .data_invalid_oe);
  fdc_host fdc_host_i (.aclk, .pins);
  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Two edges cover the one-cycle lag of the read path.
  task automatic st();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // A hang ends the run at cycle 20000, far above the cycles the sequence needs.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      fdc_host_i.ctl(rows[i].c);
      @(negedge aclk);
      chk(data_oe, rows[i].e);
      chk(data_invalid_oe, rows[i].e);
      @(posedge aclk);
    end
    axr(ECR_OFS);
    chk(rd, 32'h0);
    axr(8'h10);
    chk(rr, RESP_SLVERR);
    axw(DIETYPE_OFS, 32'h2);
    axr(DIETYPE_OFS);
    chk(rd, 32'h2);
    fdc_host_i.ctl(7'h4e);
    fdc_host_i.latch(8'h01);
    @(negedge aclk);
    chk(data_invalid_flag, 1'b0);
    repeat (READ_LAT - 1) @(posedge aclk);
    @(negedge aclk);
    chk(data_invalid_flag, 1'b0);
    @(posedge aclk);
    @(negedge aclk);
    chk(data_invalid_flag, 1'b1);
    axw(ECR_OFS, 32'h4);
    @(negedge aclk);
    chk(data_invalid_flag, 1'b0);
    fdc_host_i.wr(16'hd000);
    fdc_host_i.wr(16'h4abc);
    st();
    chk(data_out, 16'h0abc);
    fdc_host_i.wr(16'h1000);
    fdc_host_i.wr(16'h2000);
    fdc_host_i.ctl(7'h4c);
    fdc_host_i.wr(16'hd000);
    axr(LOCK_OFS);
    chk(rd[3:2], 2'h3);
    fdc_host_i.ctl(7'h4a);
    fdc_host_i.wr(16'hd000);
    axr(LOCK_OFS);
    chk(rd[2], 1'b0);
    fdc_host_i.ctl(7'h46);
    fdc_host_i.wr(16'h4123);
    fdc_host_i.ctl(7'h4e);
    axr(LOCK_OFS);
    chk(rd, 32'h5555);
    axr(ECR_OFS);
    chk(rd, 32'h0);
    fdc_host_i.latch(8'h01);
    st();
    chk(data_out, 16'h4abc);
    fdc_host_i.wr(16'hd000);
    fdc_host_i.wr(16'h4123);
    st();
    chk(data_out, 16'h0123);
    axw(ECR_OFS, 32'h2);
    fdc_host_i.ctl(7'h4f);
    axr(STATUS_OFS);
    chk(rd[0], 1'b0);
    axw(ECR_OFS, 32'h3);
    axr(STATUS_OFS);
    chk(rd[0], 1'b1);
    fdc_host_i.ctl(7'h4e);
    axr(STATUS_OFS);
    chk(rd[0], 1'b0);
    axw(ECR_OFS, 32'h8);
    fdc_host_i.slatch(8'h02);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(data_invalid_flag, 1'b0);
    fdc_host_i.tick(2);
    @(negedge aclk);
    chk(data_invalid_flag, 1'b0);
    fdc_host_i.tick(1);
    @(negedge aclk);
    chk(data_invalid_flag, 1'b1);
    chk(data_out, 16'h4000);
    s_axi_wstrb <= 4'he;
    axw(ECR_OFS, 32'h4);
    s_axi_wstrb <= 4'hf;
    axr(ECR_OFS);
    chk(rd, 32'h8);
    fdc_host_i.ctl(7'h2a);
    fdc_host_i.wr(16'h2000);
    fdc_host_i.wr(16'hd000);
    axr(LOCK_OFS);
    chk(rd[13:12], 2'h3);
    fdc_host_i.ctl(7'h2c);
    fdc_host_i.wr(16'hd000);
    axr(LOCK_OFS);
    chk(rd[12], 1'b0);
    fdc_host_i.ctl(7'h4e);
    aresetn <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    chk(data_out, 16'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    axr(ECR_OFS);
    chk(rd, 32'h0);
    results();
  end
endmodule
